// ===== rtl/spi_reg_port.sv
// Serial register port: pin synchronisers, address/data framing, burst auto-increment
module spi_reg_port
  import temp_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic nss_n,
  output logic miso_o,
  output logic miso_oe_n,
  // Register side
  input wire logic port_en,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  output reg_write_t wr_req
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] pins;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  assign pins = {nss_n, mosi, sck};

  // Three flops per pin; the first one is never looked at
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pins[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  logic rise;
  logic fall;
  logic sel;
  assign rise = sync_q[0] & ~prev_q[0];
  assign fall = ~sync_q[0] & prev_q[0];
  // Frames are ignored until the device is ready
  assign sel = ~sync_q[2] & port_en;

  // ********************************************************************
  // Framing: first byte is write flag and address, then data bytes
  // ********************************************************************
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] addr_q, addr_d;
  logic wnr_q, wnr_d;
  logic in_data_q, in_data_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic miso_q, miso_d;
  logic oe_n_q, oe_n_d;
  reg_write_t wr_q, wr_d;

  // Sample on rising edge, shift out on falling edge
  always_comb begin
    logic [7:0] byte_v;
    byte_v = {shift_q[6:0], sync_q[1]};
    bit_cnt_d = bit_cnt_q;
    addr_d = addr_q;
    wnr_d = wnr_q;
    in_data_d = in_data_q;
    shift_d = shift_q;
    tx_d = tx_q;
    miso_d = miso_q;
    oe_n_d = oe_n_q;
    wr_d = '0;
    if (!sel) begin
      bit_cnt_d = '0;
      in_data_d = 1'b0;
      oe_n_d = 1'b1;
    end else begin
      oe_n_d = 1'b0;
      if (rise) begin
        shift_d = byte_v;
        bit_cnt_d = bit_cnt_q + 3'h1;
        if (bit_cnt_q == BIT_LAST) begin
          if (!in_data_q) begin
            wnr_d = byte_v[7];
            addr_d = byte_v[6:0];
            in_data_d = 1'b1;
          end else begin
            if (wnr_q) begin
              wr_d = '{en: 1'b1, addr: addr_q, data: byte_v};
            end
            addr_d = addr_q + 7'h1;
          end
        end
      end else if (fall) begin
        // Byte boundary in data phase: load the addressed register
        if (bit_cnt_q == 3'h0 && in_data_q) begin
          tx_d = rd_data;
          miso_d = rd_data[7];
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
          miso_d = tx_q[6];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= '0;
      addr_q <= '0;
      wnr_q <= 1'b0;
      in_data_q <= 1'b0;
      shift_q <= '0;
      tx_q <= '0;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
      wr_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      addr_q <= addr_d;
      wnr_q <= wnr_d;
      in_data_q <= in_data_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      miso_q <= miso_d;
      oe_n_q <= oe_n_d;
      wr_q <= wr_d;
    end
  end

  assign miso_o = miso_q;
  assign miso_oe_n = oe_n_q;
  assign rd_addr = addr_q;
  assign wr_req = wr_q;

endmodule

// ===== rtl/temp_conv_seq.sv
// Temperature conversion sequencer: timed run, ignore of retrigger, result capture
module temp_conv_seq
  import temp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 25000
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic trigger,
  // Sensor code from the analog front end
  input wire logic [7:0] sensor_code,
  // Status and result
  output logic active,
  output logic done,
  output logic [7:0] reading
);

  // ********************************************************************
  // Sensor synchroniser
  // ********************************************************************
  // Code is held steady by the sensor while a conversion runs
  logic [7:0] code_meta_q;
  logic [7:0] code_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_meta_q <= '0;
      code_q <= '0;
    end else begin
      code_meta_q <= sensor_code;
      code_q <= code_meta_q;
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  conv_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic active_q, active_d;
  logic done_q, done_d;
  logic [7:0] reading_q, reading_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    reading_d = reading_q;
    case (state_q)
      CONV_IDLE: begin
        if (trigger) begin
          state_d = CONV_RUN;
          cnt_d = '0;
        end
      end
      CONV_RUN: begin
        // Trigger is not looked at here, so a retrigger changes nothing
        if (cnt_q == 32'(CONV_CYCLES - 1)) begin
          state_d = CONV_LATCH;
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      CONV_LATCH: begin
        // Higher sensor code means warmer: invert for minus one degree per count
        reading_d = ~code_q;
        done_d = 1'b1;
        state_d = CONV_IDLE;
      end
      default: state_d = CONV_IDLE;
    endcase
    active_d = (state_d != CONV_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CONV_IDLE;
      cnt_q <= '0;
      active_q <= 1'b0;
      done_q <= 1'b0;
      reading_q <= RESULT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      active_q <= active_d;
      done_q <= done_d;
      reading_q <= reading_d;
    end
  end

  assign active = active_q;
  assign done = done_q;
  assign reading = reading_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_active_holds: assert property (@(posedge clk) disable iff (rst)
    (state_q == CONV_RUN && cnt_q < 32'(CONV_CYCLES - 1)) |=> active_q)
    else $error("conversion flag dropped early");

  a_active_ends: assert property (@(posedge clk) disable iff (rst)
    $fell(active_q) |-> done_q && $past(cnt_q) == 32'(CONV_CYCLES - 1))
    else $error("conversion flag cleared at wrong time");

  a_result_step: assert property (@(posedge clk) disable iff (rst)
    done_q |-> reading_q == ~$past(code_q))
    else $error("result not inverted sensor code");

  a_retrig_ignored: assert property (@(posedge clk) disable iff (rst)
    (state_q == CONV_RUN && trigger && cnt_q < 32'(CONV_CYCLES - 1)) |=> cnt_q == $past(cnt_q) + 32'h1)
    else $error("retrigger disturbed conversion");

endmodule

// ===== rtl/temp_measure_and_reset_ctrl.sv
// Housekeeping top: temperature registers, receiver tuning registers and post-reset readiness
//
// Behaviour
// - Writing one to trigger bit starts a conversion; bit always reads zero.
// - Active bit reads one during conversion and zero once it finishes.
// - Receiver unavailable while converting; host waits for active flag to clear.
// - Result is 8-bit read-only, minus one degree per count, needs calibration.
// - Sensitivity setting 0x1b selects normal, 0x2d selects high sensitivity.
// - Fade setting: 0x00 normal; 0x10 improved with AFC on, 0x30 with off.
// - With narrow AFC on, offset equals setting times 488 Hz; setting resets zero.
// - No clock output activity until the device is ready after reset.
// - Read-only silicon revision code readable at address 0x10.
module temp_measure_and_reset_ctrl
  import temp_pkg::*;
#(
  // Arbitrary revision value
  parameter logic [7:0] SILICON_REV = 8'h5a,
  parameter int unsigned READY_CYCLES = READY_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int unsigned CONV_CYCLES = CONV_TIME_US * NS_PER_US / CLK_PERIOD_NS
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial register port
  input wire logic sck,
  input wire logic mosi,
  input wire logic nss_n,
  output logic miso_o,
  output logic miso_oe_n,
  // Sensor and receiver mode inputs
  input wire logic [7:0] sensor_code,
  input wire logic narrow_index_afc_enable,
  // Receiver controls
  output logic rx_allowed,
  output logic lna_high_sens,
  output logic fade_improved,
  output logic [OFFSET_W-1:0] narrow_index_freq_offset,
  // Readiness
  output logic device_ready,
  output logic ready_clock_output
);

  // ********************************************************************
  // Readiness after reset
  // ********************************************************************
  logic [31:0] ready_cnt_q, ready_cnt_d;
  logic ready_q, ready_d;

  // Counts out the wait the host also observes; serial port stays deaf meanwhile
  always_comb begin
    ready_cnt_d = ready_cnt_q;
    ready_d = ready_q;
    if (!ready_q) begin
      if (ready_cnt_q == 32'(READY_CYCLES - 1)) begin
        ready_d = 1'b1;
      end else begin
        ready_cnt_d = ready_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      ready_cnt_q <= ready_cnt_d;
      ready_q <= ready_d;
    end
  end

  // ********************************************************************
  // Ready clock output divider
  // ********************************************************************
  logic [3:0] div_q, div_d;
  logic ready_clock_output_q, ready_clock_output_d;

  // Held low until ready so the host can treat any edge as readiness
  always_comb begin
    div_d = div_q;
    ready_clock_output_d = ready_clock_output_q;
    if (!ready_q) begin
      div_d = '0;
      ready_clock_output_d = 1'b0;
    end else if (div_q == READY_CLOCK_OUTPUT_HALF - 4'h1) begin
      div_d = '0;
      ready_clock_output_d = ~ready_clock_output_q;
    end else begin
      div_d = div_q + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      ready_clock_output_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ready_clock_output_q <= ready_clock_output_d;
    end
  end

  // ********************************************************************
  // Serial port
  // ********************************************************************
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  reg_write_t wr_req;

  spi_reg_port u_port (
    .clk(clk),
    .rst(rst),
    .sck(sck),
    .mosi(mosi),
    .nss_n(nss_n),
    .miso_o(miso_o),
    .miso_oe_n(miso_oe_n),
    .port_en(ready_q),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_req(wr_req)
  );

  // ********************************************************************
  // Temperature conversion
  // ********************************************************************
  logic trig;
  logic conv_active;
  logic conv_done;
  logic [7:0] temp_reading;

  // Trigger is a write-only strobe: nothing is stored, so it reads zero
  assign trig = wr_req.en && wr_req.addr == ADDR_TEMP_CTRL && wr_req.data[TRIG_BIT];

  temp_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk(clk),
    .rst(rst),
    .trigger(trig),
    .sensor_code(sensor_code),
    .active(conv_active),
    .done(conv_done),
    .reading(temp_reading)
  );

  // ********************************************************************
  // Tuning registers
  // ********************************************************************
  logic [7:0] lna_q, lna_d;
  logic [7:0] fade_q, fade_d;
  logic [7:0] afc_ofs_q, afc_ofs_d;

  // Software writes; read-only addresses drop the data
  always_comb begin
    lna_d = lna_q;
    fade_d = fade_q;
    afc_ofs_d = afc_ofs_q;
    if (wr_req.en) begin
      case (wr_req.addr)
        ADDR_LNA: lna_d = wr_req.data;
        ADDR_FADE: fade_d = wr_req.data;
        ADDR_AFC_OFS: afc_ofs_d = wr_req.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lna_q <= LNA_NORMAL;
      fade_q <= FADE_NORMAL;
      afc_ofs_q <= AFC_OFS_RESET;
    end else begin
      lna_q <= lna_d;
      fade_q <= fade_d;
      afc_ofs_q <= afc_ofs_d;
    end
  end

  // ********************************************************************
  // Read decode
  // ********************************************************************
  always_comb begin
    case (rd_addr)
      ADDR_REVISION: rd_data = SILICON_REV;
      ADDR_TEMP_CTRL: begin
        rd_data = TEMP_CTRL_FIXED;
        rd_data[ACTIVE_BIT] = conv_active;
      end
      ADDR_TEMP_RESULT: rd_data = temp_reading;
      ADDR_LNA: rd_data = lna_q;
      ADDR_FADE: rd_data = fade_q;
      ADDR_AFC_OFS: rd_data = afc_ofs_q;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  // ********************************************************************
  // Receiver control outputs
  // ********************************************************************
  logic rx_ok_q, rx_ok_d;
  logic lna_hi_q, lna_hi_d;
  logic fade_imp_q, fade_imp_d;
  logic [OFFSET_W-1:0] offset_q, offset_d;

  // Decoded once here so the receiver sees clean registered levels
  always_comb begin
    rx_ok_d = ready_q && !conv_active;
    // Codes other than the two documented ones keep normal sensitivity
    lna_hi_d = (lna_q == LNA_HIGH);
    fade_imp_d = fade_is_improved(fade_q, narrow_index_afc_enable);
    if (narrow_index_afc_enable) begin
      offset_d = OFFSET_W'(afc_ofs_q * OFFSET_STEP_HZ);
    end else begin
      offset_d = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ok_q <= 1'b0;
      lna_hi_q <= 1'b0;
      fade_imp_q <= 1'b0;
      offset_q <= '0;
    end else begin
      rx_ok_q <= rx_ok_d;
      lna_hi_q <= lna_hi_d;
      fade_imp_q <= fade_imp_d;
      offset_q <= offset_d;
    end
  end

  assign rx_allowed = rx_ok_q;
  assign lna_high_sens = lna_hi_q;
  assign fade_improved = fade_imp_q;
  assign narrow_index_freq_offset = offset_q;
  assign device_ready = ready_q;
  assign ready_clock_output = ready_clock_output_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_trig_reads_zero: assert property (@(posedge clk) disable iff (rst)
    rd_addr == ADDR_TEMP_CTRL |-> !rd_data[TRIG_BIT] && rd_data[ACTIVE_BIT] == conv_active)
    else $error("control register read wrong");

  a_conv_starts: assert property (@(posedge clk) disable iff (rst)
    (trig && !conv_active) |=> conv_active)
    else $error("trigger did not start conversion");

  a_rx_blocked: assert property (@(posedge clk) disable iff (rst)
    conv_active |=> !rx_allowed)
    else $error("receiver allowed during conversion");

  a_lna_decode: assert property (@(posedge clk) disable iff (rst)
    (lna_q == LNA_HIGH) |=> lna_high_sens)
    else $error("high sensitivity not selected");

  a_lna_normal: assert property (@(posedge clk) disable iff (rst)
    (lna_q == LNA_NORMAL) |=> !lna_high_sens)
    else $error("normal sensitivity not selected");

  a_fade_decode: assert property (@(posedge clk) disable iff (rst)
    ((fade_q == FADE_AFC_ON && narrow_index_afc_enable) || (fade_q == FADE_AFC_OFF && !narrow_index_afc_enable))
    |=> fade_improved)
    else $error("improved margin not selected");

  a_offset_calc: assert property (@(posedge clk) disable iff (rst)
    narrow_index_afc_enable |=> narrow_index_freq_offset == OFFSET_W'($past(afc_ofs_q) * OFFSET_STEP_HZ))
    else $error("frequency offset wrong");

  a_no_clk_early: assert property (@(posedge clk) disable iff (rst)
    !ready_q |-> !ready_clock_output && !rx_allowed)
    else $error("clock output active before ready");

  a_ready_time: assert property (@(posedge clk) disable iff (rst)
    $rose(ready_q) |-> $past(ready_cnt_q) == 32'(READY_CYCLES - 1))
    else $error("ready reached at wrong count");

  a_rev_read: assert property (@(posedge clk) disable iff (rst)
    rd_addr == ADDR_REVISION |-> rd_data == SILICON_REV)
    else $error("revision code wrong");

endmodule

// ===== rtl/temp_pkg.sv
// Shared constants, register map and types for the temperature and reset housekeeping block
package temp_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Wait after reset before the device answers and clocks out
  localparam int unsigned READY_TIME_MS = 5;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned NS_PER_US = 1000;
  // Length of one temperature conversion
  localparam int unsigned CONV_TIME_US = 100;
  // Half period of the ready clock output, in system cycles
  localparam logic [3:0] READY_CLOCK_OUTPUT_HALF = 4'h4;

  // ********************************************************************
  // Register map (7-bit addresses on the serial port)
  // ********************************************************************
  localparam logic [6:0] ADDR_REVISION = 7'h10;
  localparam logic [6:0] ADDR_TEMP_CTRL = 7'h4e;
  localparam logic [6:0] ADDR_TEMP_RESULT = 7'h4f;
  localparam logic [6:0] ADDR_LNA = 7'h58;
  localparam logic [6:0] ADDR_FADE = 7'h6f;
  localparam logic [6:0] ADDR_AFC_OFS = 7'h71;

  // ********************************************************************
  // Fields and values
  // ********************************************************************
  localparam int unsigned TRIG_BIT = 3;
  localparam int unsigned ACTIVE_BIT = 2;
  // Control register: upper nibble zero, low pair reads 01
  localparam logic [7:0] TEMP_CTRL_FIXED = 8'h01;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] LNA_NORMAL = 8'h1b;
  localparam logic [7:0] LNA_HIGH = 8'h2d;
  localparam logic [7:0] FADE_NORMAL = 8'h00;
  localparam logic [7:0] FADE_AFC_ON = 8'h10;
  localparam logic [7:0] FADE_AFC_OFF = 8'h30;
  localparam logic [7:0] AFC_OFS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int unsigned OFFSET_W = 17;
  localparam logic [8:0] OFFSET_STEP_HZ = 9'h1e8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_LATCH = 2'b11
  } conv_state_t;

  // Improved fading margin code for the present AFC mode
  function automatic logic fade_is_improved(input logic [7:0] code, input logic afc_on);
    fade_is_improved = afc_on ? (code == FADE_AFC_ON) : (code == FADE_AFC_OFF);
  endfunction

endpackage

// ===== verif/spi_host_model.sv
// Host side model: serial master that frames register accesses
module spi_host_model (
  // System
  input wire logic clk,
  // Serial pins
  output logic sck,
  output logic mosi,
  output logic nss_n,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  // Readiness seen by the host
  input wire logic ready_clock_output
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock parked low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    nss_n = 1'b1;
  end

  // One byte, MSB first; 5 clk phases keep clear of the 4 clk minimum
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (5) @(posedge clk);
      sck <= 1'b1;
      // A released line reads as the inverse, so a missing enable shows up as bad data
      rx[i] = miso_oe_n ? ~miso_o : miso_o;
      repeat (5) @(posedge clk);
      sck <= 1'b0;
    end
  endtask

  // Address byte then one data byte; mosi flips after release so stale data never looks valid
  task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] junk;
    @(posedge clk);
    nss_n <= 1'b0;
    shift({wr, a}, junk);
    shift(d, q);
    repeat (5) @(posedge clk);
    nss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (5) @(posedge clk);
  endtask

  // No access until the ready clock has started toggling
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 1000 && !ok; n++) begin
      @(posedge clk);
      ok = (ready_clock_output === 1'b1);
    end
    repeat (5) @(posedge clk);
  endtask
endmodule

// ===== verif/temp_measure_and_reset_ctrl_tb.sv
// Self-checking bench for the temperature and reset housekeeping block
module temp_measure_and_reset_ctrl_tb import temp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RDY = 50;
  localparam int CONV = 600;
  // Arbitrary revision value
  localparam logic [7:0] SREV = 8'h3c;
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic afc;
  } row_t;
  // Reset values first, then writes, read-only places and an unmapped read
  localparam row_t ROWS [14] = '{
    '{1'b0, ADDR_LNA, 8'h00, LNA_NORMAL, 1'b0},
    '{1'b0, ADDR_FADE, 8'h00, FADE_NORMAL, 1'b0},
    '{1'b0, ADDR_AFC_OFS, 8'h00, 8'h00, 1'b1},
    '{1'b0, ADDR_TEMP_RESULT, 8'h00, 8'h00, 1'b0},
    '{1'b1, ADDR_TEMP_CTRL, 8'hf7, 8'h01, 1'b0},
    '{1'b1, ADDR_LNA, LNA_HIGH, LNA_HIGH, 1'b0},
    '{1'b1, ADDR_LNA, LNA_NORMAL, LNA_NORMAL, 1'b0},
    '{1'b1, ADDR_FADE, FADE_AFC_OFF, FADE_AFC_OFF, 1'b0},
    '{1'b0, ADDR_FADE, 8'h00, FADE_AFC_OFF, 1'b1},
    '{1'b1, ADDR_FADE, FADE_AFC_ON, FADE_AFC_ON, 1'b1},
    '{1'b1, ADDR_AFC_OFS, 8'hff, 8'hff, 1'b1},
    '{1'b1, ADDR_AFC_OFS, 8'h05, 8'h05, 1'b0},
    '{1'b1, ADDR_REVISION, 8'hff, SREV, 1'b0},
    '{1'b1, 7'h20, 8'h5a, UNMAPPED_READ, 1'b0}
  };
  logic clk, rst, sck, mosi, nss_n, miso_o, miso_oe_n, afc;
  logic rx_allowed, lna_high_sens, fade_improved, device_ready, rco;
  logic [7:0] sensor_code, q, lna, fade, ofs;
  logic [OFFSET_W-1:0] freq_ofs;
  int miscompares = 0;
  int n_tests = 0;
  int lowcnt = 0;
  int low0 = 0;
  int n;
  bit ok;

  temp_measure_and_reset_ctrl #(.SILICON_REV(SREV), .READY_CYCLES(RDY), .CONV_CYCLES(CONV))
    i_temp_measure_and_reset_ctrl (.clk(clk), .rst(rst), .sck(sck), .mosi(mosi), .nss_n(nss_n),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sensor_code(sensor_code), .narrow_index_afc_enable(afc),
    .rx_allowed(rx_allowed), .lna_high_sens(lna_high_sens), .fade_improved(fade_improved),
    .narrow_index_freq_offset(freq_ofs), .device_ready(device_ready), .ready_clock_output(rco));
  spi_host_model i_spi_host_model (.clk(clk), .sck(sck), .mosi(mosi), .nss_n(nss_n),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ready_clock_output(rco));

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cycles with the receiver held off while ready
  always @(posedge clk) begin
    if (device_ready === 1'b1 && rx_allowed === 1'b0) lowcnt <= lowcnt + 1;
  end

  task automatic cmp(input logic [16:0] got, input logic [16:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_spi_host_model.frame(1'b0, a, 8'h00, d);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    i_spi_host_model.frame(1'b1, a, d, junk);
  endtask
  // Reset pulse; the ready clock must stay silent until the wait has run out
  task automatic do_reset(input int hold);
    bit quiet;
    quiet = 1'b1;
    rst <= 1'b1;
    repeat (hold) @(posedge clk);
    #1;
    cmp({miso_oe_n, device_ready, rco, rx_allowed}, 4'b1000, "in reset");
    @(posedge clk);
    rst <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 4 * RDY && !ok; ) begin
      @(posedge clk);
      #1;
      n++;
      ok = (device_ready === 1'b1);
      if (!ok && (rco !== 1'b0 || rx_allowed !== 1'b0)) quiet = 1'b0;
    end
    cmp(17'(n), 17'(RDY), "ready delay");
    cmp(quiet, 1'b1, "quiet before ready");
    if (ok) i_spi_host_model.wait_ready(ok);
    // A ready clock that never starts is a hang and counts against the run
    if (!ok) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    // Power-on reset comes from the bench alone; the host model never drives the pin
    rst = 1'b1;
    afc = 1'b0;
    sensor_code = 8'h64;
    lna = LNA_NORMAL;
    fade = FADE_NORMAL;
    ofs = 8'h00;
    do_reset(2);
    // Table of register accesses and the receiver controls they imply
    foreach (ROWS[k]) begin
      afc <= ROWS[k].afc;
      if (ROWS[k].wr) wr(ROWS[k].addr, ROWS[k].wdata);
      rd(ROWS[k].addr, q);
      cmp(q, ROWS[k].rexp, "readback");
      case (ROWS[k].addr)
        ADDR_LNA: lna = ROWS[k].rexp;
        ADDR_FADE: fade = ROWS[k].rexp;
        ADDR_AFC_OFS: ofs = ROWS[k].rexp;
        default: ;
      endcase
      cmp(lna_high_sens, lna == 8'h2d, "sensitivity");
      cmp(fade_improved, ROWS[k].afc ? fade == 8'h10 : fade == 8'h30, "fade");
      cmp(freq_ofs, ROWS[k].afc ? ofs * 17'd488 : 17'd0, "offset");
    end
    $display("register table done");
    // Conversion with a retrigger in mid-run; the length must not grow
    low0 = lowcnt;
    wr(ADDR_TEMP_CTRL, 8'h08);
    rd(ADDR_TEMP_CTRL, q);
    cmp(q, 8'h05, "active flag");
    wr(ADDR_TEMP_CTRL, 8'h08);
    for (n = 0; n < 2 * CONV && rx_allowed !== 1'b1; n++) @(posedge clk);
    if (n >= 2 * CONV) begin
      miscompares++;
      tally_and_finish();
    end
    cmp(17'(lowcnt - low0), 17'(CONV + 1), "conversion length");
    rd(ADDR_TEMP_CTRL, q);
    cmp(q, 8'h01, "flag cleared");
    rd(ADDR_TEMP_RESULT, q);
    // Cast first: inverted inside the wide compare argument the upper bits would turn to ones
    cmp(q, 8'(~8'h64), "reading");
    $display("conversion done");
    // Manual reset after the conversion restores the sensitivity setting
    wr(ADDR_LNA, LNA_HIGH);
    do_reset(25);
    cmp(lna_high_sens, 1'b0, "sensitivity after reset");
    rd(ADDR_LNA, q);
    cmp(q, LNA_NORMAL, "setting after reset");
    $display("manual reset done");
    tally_and_finish();
  end
endmodule
